// ==== verilog/odad_pkg.sv ====
/*
  odad_pkg: shared constants and types for the data operand address decoder:
  register offsets, reset values, field positions and the decode result carrier.
  Assumes one 100 MHz clock and a 32-bit Avalon-MM register bus.
*/
package odad_pkg;

  // register byte offsets on the Avalon-MM slave
  localparam logic [4:0] OFS_CTRL    = 5'h00;
  localparam logic [4:0] OFS_PTR0    = 5'h04;
  localparam logic [4:0] OFS_PTR1    = 5'h08;
  localparam logic [4:0] OFS_PTR2    = 5'h0C;
  localparam logic [4:0] OFS_BANK    = 5'h10;
  localparam logic [4:0] OFS_WORD    = 5'h14;
  localparam logic [4:0] OFS_RESULT  = 5'h18;

  // values after reset
  localparam logic        RST_EXT    = 1'h0;
  localparam logic [11:0] RST_PTR    = 12'h000;
  localparam logic [3:0]  RST_BANK   = 4'h0;
  localparam logic [15:0] RST_WORD   = 16'h0000;

  // access bank split and the upper access region
  localparam logic [7:0]  ACC_SPLIT  = 8'h60;
  localparam logic [3:0]  ACC_HI_BANK = 4'hF;
  localparam logic [3:0]  ACC_LO_BANK = 4'h0;

  // program word fields
  localparam int CLS_MSB   = 15;
  localparam int CLS_LSB   = 14;
  localparam int ACC_BIT   = 8;
  localparam int OPI_MSB   = 13;
  localparam int OPI_LSB   = 8;
  localparam int EXT_MSB   = 13;
  localparam int EXT_LSB   = 11;
  localparam int INH_COUNT = 24;   // valid inherent/literal opcode indices

  // pointer-access operand addresses (indirect through pointers 0, 1, 2)
  localparam logic [11:0] IND0_ADDR = 12'hFEF;
  localparam logic [11:0] IND1_ADDR = 12'hFE7;
  localparam logic [11:0] IND2_ADDR = 12'hFDF;

  // result register field positions
  localparam int RES_ADDR_LSB = 0;
  localparam int RES_MODE_LSB = 12;
  localparam int RES_NOP_BIT  = 15;
  localparam int RES_EXT_LSB  = 16;
  localparam int RES_EXTV_BIT = 19;

  typedef enum logic [1:0] {
    CLS_INHERENT,
    CLS_BYTE,
    CLS_BIT,
    CLS_EXTENDED
  } odad_class_t;

  typedef enum logic [2:0] {
    MODE_NONE,
    MODE_ACCESS,
    MODE_BANKED,
    MODE_INDEXED,
    MODE_INDIRECT
  } odad_mode_t;

  // one decode outcome
  typedef struct packed {
    logic [11:0] addr;
    odad_mode_t  mode;
    logic        nop;
    logic [2:0]  ext_op;
    logic        ext_valid;
  } odad_result_t;

  // operating context of the decoder
  typedef struct packed {
    logic        ext_en;
    logic [11:0] ptr0;
    logic [11:0] ptr1;
    logic [11:0] ptr2;
    logic [3:0]  bank;
  } odad_ctx_t;

endpackage : odad_pkg

// ==== verilog/odad_decode.sv ====
/*
  odad_decode: combinational operand decode of one program word.
  Assumes the caller registers the result; no state is held here.
*/
module odad_decode (
  input  wire logic [15:0]           word,
  input  wire odad_pkg::odad_ctx_t   ctx,
  output odad_pkg::odad_result_t     res
);

  // pointer-access operand addresses resolve to the pointer value itself
  function automatic logic [11:0] resolve(input logic [11:0] a,
                                          input odad_pkg::odad_ctx_t c);
    if (a == odad_pkg::IND0_ADDR) begin
      resolve = c.ptr0;
    end else if (a == odad_pkg::IND1_ADDR) begin
      resolve = c.ptr1;
    end else if (a == odad_pkg::IND2_ADDR) begin
      resolve = c.ptr2;
    end else begin
      resolve = a;
    end
  endfunction : resolve

  odad_pkg::odad_class_t cls;
  logic [7:0]            f;
  logic                  a_bit;
  logic [11:0]           direct;

  assign cls   = odad_pkg::odad_class_t'(word[odad_pkg::CLS_MSB:odad_pkg::CLS_LSB]);
  assign f     = word[7:0];
  assign a_bit = word[odad_pkg::ACC_BIT];

  // address mode selection; only byte and bit classes touch memory
  always_comb begin
    res        = '0;
    res.mode   = odad_pkg::MODE_NONE;
    direct     = '0;
    unique case (cls)
      odad_pkg::CLS_BYTE, odad_pkg::CLS_BIT: begin
        if (a_bit) begin
          direct   = {ctx.bank, f};
          res.mode = odad_pkg::MODE_BANKED;
        end else if (ctx.ext_en && f < odad_pkg::ACC_SPLIT) begin
          res.addr = ctx.ptr2 + {4'h0, f};
          res.mode = odad_pkg::MODE_INDEXED;
        end else if (f < odad_pkg::ACC_SPLIT) begin
          direct   = {odad_pkg::ACC_LO_BANK, f};
          res.mode = odad_pkg::MODE_ACCESS;
        end else begin
          // access bank from the 0x60 split up; same with or without extension
          direct   = {(f[7] ? odad_pkg::ACC_HI_BANK : odad_pkg::ACC_LO_BANK), f};
          res.mode = odad_pkg::MODE_ACCESS;
        end
        if (res.mode != odad_pkg::MODE_INDEXED) begin
          // indirect through any pointer is untouched by the extension
          res.addr = resolve(direct, ctx);
          if (res.addr != direct) begin
            res.mode = odad_pkg::MODE_INDIRECT;
          end
        end
      end
      odad_pkg::CLS_INHERENT: begin
        // inherent and literal words ignore the extension bit entirely
        res.nop = (word[odad_pkg::OPI_MSB:odad_pkg::OPI_LSB]
                   >= 6'(odad_pkg::INH_COUNT));
      end
      odad_pkg::CLS_EXTENDED: begin
        res.ext_op    = word[odad_pkg::EXT_MSB:odad_pkg::EXT_LSB];
        res.ext_valid = ctx.ext_en;
        res.nop       = !ctx.ext_en;
      end
    endcase
  end

endmodule : odad_decode

// ==== verilog/odad_top.sv ====
/*
  odad_top: data operand address decoder with its Avalon-MM register slave.
  Software loads the context (extension enable, pointers, bank) and a program
  word; the decode outcome is latched into a readable result register.
  Assumes a single 100 MHz clock mclk and synchronous active-high reset rst.
*/
// Decided for this implementation: the register offsets and the Avalon-MM register port.
module odad_top (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest
);

  odad_pkg::odad_ctx_t    ctx_q;
  logic [15:0]            word_q;
  odad_pkg::odad_result_t res_q;
  odad_pkg::odad_result_t res_d;
  logic                   ack_q;
  logic [31:0]            rdata_q;
  logic                   wr_take;
  logic [31:0]            wmask;
  logic [31:0]            wmdata;

  // one wait state per request keeps the read mux off the bus path
  assign waitrequest = (read | write) & ~ack_q;
  assign wr_take     = write & ack_q;
  assign readdata    = rdata_q;

  // expands byte enables to a write mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  // lane mask and masked write data, shared by every register update
  assign wmask  = be_mask(byteenable);
  assign wmdata = writedata & wmask;

  // handshake phase: ack toggles so each request costs two edges
  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read | write) & ~ack_q;
    end
  end

  // context registers written by software steer the decoder
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctx_q.ext_en <= odad_pkg::RST_EXT;
      ctx_q.ptr0   <= odad_pkg::RST_PTR;
      ctx_q.ptr1   <= odad_pkg::RST_PTR;
      ctx_q.ptr2   <= odad_pkg::RST_PTR;
      ctx_q.bank   <= odad_pkg::RST_BANK;
    end else if (wr_take) begin
      unique case (address)
        odad_pkg::OFS_CTRL: ctx_q.ext_en <= (ctx_q.ext_en & ~wmask[0]) | wmdata[0];
        odad_pkg::OFS_PTR0: ctx_q.ptr0 <= (ctx_q.ptr0 & ~wmask[11:0]) | wmdata[11:0];
        odad_pkg::OFS_PTR1: ctx_q.ptr1 <= (ctx_q.ptr1 & ~wmask[11:0]) | wmdata[11:0];
        odad_pkg::OFS_PTR2: ctx_q.ptr2 <= (ctx_q.ptr2 & ~wmask[11:0]) | wmdata[11:0];
        odad_pkg::OFS_BANK: ctx_q.bank <= (ctx_q.bank & ~wmask[3:0]) | wmdata[3:0];
        default: ;
      endcase
    end
  end

  // program word register; writing it starts a decode
  always_ff @(posedge mclk) begin
    if (rst) begin
      word_q <= odad_pkg::RST_WORD;
    end else if (wr_take && address == odad_pkg::OFS_WORD) begin
      word_q <= (word_q & ~wmask[15:0]) | wmdata[15:0];
    end
  end

  odad_decode u_decode (
    .word (word_q),
    .ctx  (ctx_q),
    .res  (res_d)
  );

  // result follows the decoder one edge later so a read sees a settled value
  always_ff @(posedge mclk) begin
    if (rst) begin
      res_q <= '0;
    end else begin
      res_q <= res_d;
    end
  end

  // read data captured in the wait cycle, stands at the completing edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (read & ~ack_q) begin
      unique case (address)
        odad_pkg::OFS_CTRL:   rdata_q <= {31'h0, ctx_q.ext_en};
        odad_pkg::OFS_PTR0:   rdata_q <= {20'h0, ctx_q.ptr0};
        odad_pkg::OFS_PTR1:   rdata_q <= {20'h0, ctx_q.ptr1};
        odad_pkg::OFS_PTR2:   rdata_q <= {20'h0, ctx_q.ptr2};
        odad_pkg::OFS_BANK:   rdata_q <= {28'h0, ctx_q.bank};
        odad_pkg::OFS_WORD:   rdata_q <= {16'h0, word_q};
        odad_pkg::OFS_RESULT: rdata_q <= {12'h0, res_q.ext_valid, res_q.ext_op,
                                          res_q.nop, res_q.mode, res_q.addr};
        default:              rdata_q <= '0;   // unmapped reads as zero
      endcase
    end
  end

endmodule : odad_top

// ==== tb/odad_top_properties.sv ====
/*
  odad_top_properties: bus timing and result-field checks on odad_top.
  Assumes the bind below and that it sees only the top ports.
*/
module odad_top_properties (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest
);
  // a completed read of the result register
  wire res_rd = read && !waitrequest && address == odad_pkg::OFS_RESULT;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // one wait state, then done; a long stall would hang software
  a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("wait state too long");
  a_idle_nowait: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest while idle");
  a_wait_again: assert property ((read || write) && !waitrequest |=> waitrequest || !(read || write))
    else $error("held request not restarted");
  a_rdata_hold: assert property (!(read && waitrequest) |=> $stable(readdata))
    else $error("readdata changed without read");
  a_nop_clear: assert property (res_rd && readdata[15] |-> readdata[14:0] == 15'h0000)
    else $error("nop result not cleared");
  a_ext_valid: assert property (res_rd && readdata[19] |-> !readdata[15])
    else $error("extra opcode flagged as nop");
  a_mode_legal: assert property (res_rd |-> readdata[14:12] <= 3'h4 && readdata[31:20] == 12'h000)
    else $error("bad result fields");
  a_unmapped_zero: assert property (read && !waitrequest && address > 5'h18 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  // main scenarios reached
  c_indexed: cover property (res_rd && readdata[14:12] == 3'h3);
  c_indirect: cover property (res_rd && readdata[14:12] == 3'h4);
  c_nop: cover property (res_rd && readdata[15]);
endmodule : odad_top_properties

bind odad_top odad_top_properties u_props (.mclk(mclk), .rst(rst), .address(address),
  .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest));

// ==== tb/tb_data_operand_address_decode.sv ====
/*
  tb_data_operand_address_decode: random and corner decodes through the bus.
  Assumes odad_top and its checker bind are compiled first.
*/
module tb_data_operand_address_decode;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst, read, write, waitrequest;
  logic [4:0]  address;
  logic [31:0] writedata, readdata, rd, r1, r2;
  logic [3:0]  byteenable;
  int          n_mismatch, n_checks, seed;
  // corner words: {extension enable, program word}
  logic [16:0] tbl [12] = '{17'h1405F, 17'h14060, 17'h14080, 17'h140FF, 17'h141EF, 17'h181E7,
    17'h181DF, 17'h0405F, 17'h041EF, 17'h11800, 17'h01700, 17'h0E000};

  odad_top uut (.mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  // hold the request until waitrequest is seen low at a rising edge
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    @(posedge mclk);
    while (waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        n_mismatch++;
        test_done;
      end
      @(posedge mclk);
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // let one edge pass so the next call never re-drives in this step
    @(posedge mclk);
  endtask : bus

  function logic [31:0] exp_res(input logic e, input logic [11:0] p0, p1, p2,
                                input logic [3:0] bk, input logic [15:0] w);
    logic [11:0] a;
    logic [2:0]  m;
    a = {w[7] ? 4'hF : 4'h0, w[7:0]};
    m = 3'h1;
    if (w[15:14] == 2'h0) return (w[13:8] >= 6'h18) ? 32'h00008000 : 32'h0;
    // a refused extra opcode still shows its opcode field beside the nop flag
    if (w[15:14] == 2'h3) return {12'h0, e, w[13:11], !e, 15'h0};
    if (w[8]) begin
      a = {bk, w[7:0]};
      m = 3'h2;
    end else if (e && w[7:0] <= 8'h5F) return {17'h0, 3'h3, p2 + {4'h0, w[7:0]}};
    if (a == odad_pkg::IND0_ADDR) return {17'h0, 3'h4, p0};
    if (a == odad_pkg::IND1_ADDR) return {17'h0, 3'h4, p1};
    if (a == odad_pkg::IND2_ADDR) return {17'h0, 3'h4, p2};
    return {17'h0, m, a};
  endfunction : exp_res

  task run_case(input logic e, input logic [11:0] p0, p1, p2,
                input logic [3:0] bk, input logic [15:0] w);
    bus(1'b1, odad_pkg::OFS_CTRL, {31'h0, e}, rd);
    bus(1'b1, odad_pkg::OFS_PTR0, {20'h0, p0}, rd);
    bus(1'b1, odad_pkg::OFS_PTR1, {20'h0, p1}, rd);
    bus(1'b1, odad_pkg::OFS_PTR2, {20'h0, p2}, rd);
    bus(1'b1, odad_pkg::OFS_BANK, {28'h0, bk}, rd);
    bus(1'b1, odad_pkg::OFS_WORD, {16'h0, w}, rd);
    bus(1'b0, odad_pkg::OFS_RESULT, 32'h0, rd);
    chk(rd, exp_res(e, p0, p1, p2, bk, w));
  endtask : run_case

  // about 4800 cycles are needed; the margin covers a slow slave
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    test_done;
  end

  initial begin
    seed = 32'h6EA2ED5F;
    {rst, read, write, address, writedata, byteenable} = {3'h4, 5'h00, 32'h0, 4'hF};
    n_mismatch = 0;
    n_checks = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    bus(1'b0, odad_pkg::OFS_RESULT, 32'h0, rd);
    chk(rd, 32'h0);
    // a single-lane write touches only its byte of the pointer
    byteenable <= 4'h2;
    bus(1'b1, odad_pkg::OFS_PTR0, 32'h00000FFF, rd);
    byteenable <= 4'hF;
    bus(1'b0, odad_pkg::OFS_PTR0, 32'h0, rd);
    chk(rd, 32'h00000F00);
    // wrap, window edges, both access halves, indirect aliases, invalid words
    foreach (tbl[i]) run_case(tbl[i][16], 12'hABC, 12'h123, 12'hFF0, 4'hF, tbl[i][15:0]);
    for (int i = 0; i < 16; i++) run_case(i[3], 12'h0, 12'h0, 12'h0, 4'h0, {2'h3, i[2:0], 11'h0});
    bus(1'b1, odad_pkg::OFS_RESULT, 32'hFFFFFFFF, rd);
    bus(1'b0, odad_pkg::OFS_RESULT, 32'h0, rd);
    chk(rd, exp_res(1'b1, 12'h0, 12'h0, 12'h0, 4'h0, 16'hF800));
    bus(1'b0, 5'h1C, 32'h0, rd);
    chk(rd, 32'h0);
    for (int i = 0; i < 200; i++) begin
      r1 = $random(seed);
      r2 = $random(seed);
      run_case(r1[31], r1[11:0], r1[23:12], r2[11:0], r2[15:12], r2[31:16]);
    end
    test_done;
  end
endmodule : tb_data_operand_address_decode
